// *** sptx_pkg.sv ***
package sptx_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_BAUD = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;
	localparam logic [7:0] ADDR_ICLR = 8'h10;
	localparam logic [7:0] ADDR_IEN = 8'h14;
	localparam int CTRL_W = 12;
	localparam int C_EN = 0;
	localparam int C_B8 = 1;
	localparam int C_U2X = 2;
	localparam int C_SYNC = 3;
	localparam int C_MSTR = 4;
	localparam int C_POL = 5;
	localparam int C_STOP = 6;
	localparam int C_PODD = 7;
	localparam int C_PEN = 8;
	localparam int C_CSZ = 9;
	localparam logic [11:0] CTRL_RST = 12'h600;
	localparam int BAUD_W = 12;
	localparam logic [11:0] BAUD_RST = 12'h000;
	localparam int ST_EMPTY = 0;
	localparam int ST_TXC = 1;
	localparam logic [1:0] IEN_RST = 2'h0;
	localparam logic [3:0] PRE_NORM = 4'hf;
	localparam logic [3:0] PRE_DBL = 4'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int FRAME_W = 13;
endpackage

// *** sptx_tick.sv ***
`timescale 1ns/100ps
`default_nettype none
module sptx_tick #(
	parameter int DIV_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [DIV_W-1:0] div,
	input wire logic double_speed,
	input wire logic sync_mode,
	input wire logic sync_master,
	input wire logic clk_pol,
	input wire logic active,
	input wire logic xck_in,
	output logic bit_tick,
	output logic xck_out,
	output logic xck_oe_n
);
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic [3:0] pre;
		logic s1;
		logic s2;
		logic d;
		logic xo;
		logic oe_n;
		logic tick;
	} sptx_tick_t;
	sptx_tick_t st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		st_nxt.s1 = xck_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.d = st_r.s2;
		if (sync_mode && !sync_master) begin
			// Change edge of the external transfer clock
			if (st_r.s2 != st_r.d && st_r.s2 == !clk_pol) begin
				st_nxt.tick = 1'b1; // [R2]
			end
		end else if (st_r.cnt == '0) begin
			st_nxt.cnt = div;
			if (sync_mode) begin
				if (active) begin
					st_nxt.xo = !st_r.xo;
					st_nxt.tick = (!st_r.xo) == !clk_pol;
				end
			end else begin
				st_nxt.pre = st_r.pre + 4'h1;
				if (st_r.pre == (double_speed ? sptx_pkg::PRE_DBL : sptx_pkg::PRE_NORM)) begin
					st_nxt.pre = 4'h0;
					st_nxt.tick = 1'b1; // [R5]
				end
			end
		end else begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
		st_nxt.oe_n = !(sync_mode && sync_master && active);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '{oe_n: 1'b1, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bit_tick = st_r.tick;
	assign xck_out = st_r.xo;
	assign xck_oe_n = st_r.oe_n;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_slave_edge_tick: assert property ((sync_mode && !sync_master && st_r.s2 && !st_r.d
		&& !clk_pol) |=> bit_tick) else $error("External change edge gave no tick"); // [R2]
	a_async_prescale: assert property ((!sync_mode && bit_tick) |-> st_r.pre == 4'h0)
		else $error("Async tick off prescaler wrap"); // [R5]
endmodule
`default_nettype wire

// *** sptx_shift.sv ***
`timescale 1ns/100ps
`default_nettype none
module sptx_shift (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic [8:0] data,
	input wire logic [3:0] nbits,
	input wire logic par_en,
	input wire logic par_odd,
	input wire logic two_stop,
	input wire logic bit_tick,
	output logic busy,
	output logic txd,
	output logic done
);
	typedef enum {SH_IDLE, SH_RUN} sptx_sh_state_t;
	typedef struct packed {
		sptx_sh_state_t state;
		logic [sptx_pkg::FRAME_W-1:0] sr;
		logic [3:0] cnt;
		logic [3:0] len;
		logic busy;
		logic txd;
		logic done;
	} sptx_sh_t;
	sptx_sh_t st_r, st_nxt;

	always_comb begin
		logic [sptx_pkg::FRAME_W-1:0] fr;
		logic par;
		fr = '1;
		par = par_odd;
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		fr[0] = 1'b0; // [R18]
		for (int i = 0; i < 9; i++) begin
			if (i < int'(nbits)) begin
				fr[i+1] = data[i]; // [R6]
				par = par ^ data[i];
			end
		end
		if (par_en) begin
			fr[int'(nbits)+1] = par; // [R17]
		end
		case (st_r.state)
			SH_IDLE: begin
				if (load) begin
					st_nxt.sr = fr;
					st_nxt.len = nbits + 4'(par_en) + 4'(two_stop) + 4'h2;
					st_nxt.cnt = st_nxt.len;
					st_nxt.state = SH_RUN; // [R5]
				end
			end
			SH_RUN: begin
				if (bit_tick) begin
					if (st_r.cnt != 4'h0) begin
						st_nxt.txd = st_r.sr[0];
						st_nxt.sr = {1'b1, st_r.sr[sptx_pkg::FRAME_W-1:1]};
						st_nxt.cnt = st_r.cnt - 4'h1;
					end else begin
						st_nxt.state = SH_IDLE;
						st_nxt.txd = 1'b1; // [R19]
						st_nxt.done = 1'b1;
					end
				end
			end
			default: begin
				st_nxt.state = SH_IDLE;
			end
		endcase
		st_nxt.busy = st_nxt.state == SH_RUN;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '{state: SH_IDLE, txd: 1'b1, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy = st_r.busy;
	assign txd = st_r.txd;
	assign done = st_r.done;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_start_low: assert property ((st_r.state == SH_RUN && bit_tick && st_r.cnt == st_r.len)
		|=> !txd) else $error("Frame did not open with low start bit"); // [R18]
	a_idle_high: assert property ((st_r.state == SH_IDLE) |-> txd)
		else $error("Line not high while idle"); // [R19]
	a_last_stop: assert property ((st_r.state == SH_RUN && bit_tick && st_r.cnt == 4'h1)
		|=> txd) else $error("Last bit of frame not a stop bit"); // [R18]
endmodule
`default_nettype wire

// *** sptx_top.sv ***
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [R1] Transmit enable hands the serial output pin to the transmitter.
// [R2] Synchronous mode uses the transfer clock pin to pace bits.
// [R3] Writing the data register loads the buffer and starts sending.
// [R4] Buffer moves to shift register whenever the shift register is idle.
// [R5] Loaded shift register sends one frame at divider or external clock rate.
// [R6] Data bits above the configured character size are ignored.
// [R7] Ninth bit comes from the control bit; software sets it first.
// [R8] Buffer-empty and transmit-complete flags each raise their own interrupt.
// [R9] Buffer-empty flag is high exactly when the buffer holds nothing.
// [R10] Software writes zero to the buffer-empty flag position.
// [R11] Buffer-empty interrupt stays raised while enabled and the flag is set.
// [R12] A data register write clears the buffer-empty flag.
// [R13] Software configures rate, mode and format before transmitting.
// [R14] Software writes a character only after buffer-empty is seen set.
// [R15] Transmit-complete sets when frame ends with buffer empty; write one clears.
// [R16] Disabling waits for buffer and shift register to drain, then frees pin.
// [R17] Parity bit sits after the last data bit, before the stop bits.
// [R18] Frame: low start bit, data LSB first, one or two high stops.
// [R19] Enabled with no frame in progress, the line idles high.
module sptx_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [sptx_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [sptx_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic txd_out,
	output logic txd_oe_n,
	input wire logic xck_in,
	output logic xck_out,
	output logic xck_oe_n,
	output logic irq
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_hold;
		logic w_hold;
		logic [sptx_pkg::ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [sptx_pkg::CTRL_W-1:0] ctrl;
		logic [sptx_pkg::BAUD_W-1:0] baud;
		logic [1:0] ien;
		logic [8:0] buf_data;
		logic buf_full;
		logic tx_complete;
		logic active;
		logic oe_n;
		logic irq;
	} sptx_top_t;
	sptx_top_t st_r, st_nxt;

	logic load_w;
	logic sh_busy;
	logic sh_done;
	logic sh_txd;
	logic bit_tick;
	logic [3:0] nbits;
	logic [1:0] stat;

	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] be
	);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return (old & ~m) | (wd & m);
	endfunction

	// Character size field to number of data bits
	always_comb begin
		case (st_r.ctrl[sptx_pkg::C_CSZ +: 3])
			3'h0: nbits = 4'h5;
			3'h1: nbits = 4'h6;
			3'h2: nbits = 4'h7;
			3'h7: nbits = 4'h9;
			default: nbits = 4'h8;
		endcase
	end

	assign stat = {st_r.tx_complete, !st_r.buf_full}; // [R9]
	assign load_w = st_r.buf_full && !sh_busy && st_r.active; // [R4]

	always_comb begin
		logic wr_go;
		logic [31:0] wm;
		wr_go = 1'b0;
		wm = '0;
		st_nxt = st_r;
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_hold = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_hold = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (load_w) begin
			st_nxt.buf_full = 1'b0;
		end
		wr_go = st_nxt.aw_hold && st_nxt.w_hold && !st_nxt.bvalid;
		if (wr_go) begin
			st_nxt.aw_hold = 1'b0;
			st_nxt.w_hold = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = sptx_pkg::RESP_OKAY;
			case (st_nxt.awaddr)
				sptx_pkg::ADDR_DATA: begin
					if (st_nxt.wstrb[0]) begin
						st_nxt.buf_data = {st_r.ctrl[sptx_pkg::C_B8], st_nxt.wdata[7:0]}; // [R7]
						st_nxt.buf_full = 1'b1; // [R3] [R12]
					end
				end
				sptx_pkg::ADDR_CTRL: begin
					wm = merge(32'(st_r.ctrl), st_nxt.wdata, st_nxt.wstrb);
					st_nxt.ctrl = wm[sptx_pkg::CTRL_W-1:0];
				end
				sptx_pkg::ADDR_BAUD: begin
					wm = merge(32'(st_r.baud), st_nxt.wdata, st_nxt.wstrb);
					st_nxt.baud = wm[sptx_pkg::BAUD_W-1:0];
				end
				sptx_pkg::ADDR_ICLR: begin
					if (st_nxt.wstrb[0] && st_nxt.wdata[sptx_pkg::ST_TXC]) begin
						st_nxt.tx_complete = 1'b0; // [R15]
					end
				end
				sptx_pkg::ADDR_IEN: begin
					if (st_nxt.wstrb[0]) begin
						st_nxt.ien = st_nxt.wdata[1:0];
					end
				end
				sptx_pkg::ADDR_STAT: begin
					st_nxt.bresp = sptx_pkg::RESP_OKAY;
				end
				default: begin
					st_nxt.bresp = sptx_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Completion event wins over a same-cycle clear
		if (sh_done && !st_r.buf_full) begin
			st_nxt.tx_complete = 1'b1; // [R15]
		end
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = sptx_pkg::RESP_OKAY;
			st_nxt.rdata = '0;
			case (s_axi_araddr)
				sptx_pkg::ADDR_DATA: st_nxt.rdata = 32'(st_r.buf_data);
				sptx_pkg::ADDR_CTRL: st_nxt.rdata = 32'(st_r.ctrl);
				sptx_pkg::ADDR_BAUD: st_nxt.rdata = 32'(st_r.baud);
				sptx_pkg::ADDR_STAT: st_nxt.rdata = 32'(stat);
				sptx_pkg::ADDR_ICLR: st_nxt.rdata = '0;
				sptx_pkg::ADDR_IEN: st_nxt.rdata = 32'(st_r.ien);
				default: st_nxt.rresp = sptx_pkg::RESP_SLVERR;
			endcase
		end
		st_nxt.arready = !st_nxt.rvalid;
		st_nxt.awready = !st_nxt.aw_hold && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_hold && !st_nxt.bvalid;
		// Stay active until buffer and shifter drain
		st_nxt.active = st_nxt.ctrl[sptx_pkg::C_EN] || sh_busy || load_w
			|| st_nxt.buf_full; // [R16]
		st_nxt.oe_n = !st_nxt.active; // [R1] [R16]
		st_nxt.irq = |(stat & st_r.ien); // [R8] [R11]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '{ctrl: sptx_pkg::CTRL_RST, baud: sptx_pkg::BAUD_RST,
				ien: sptx_pkg::IEN_RST, oe_n: 1'b1, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	sptx_tick #(
		.DIV_W(sptx_pkg::BAUD_W)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.div(st_r.baud),
		.double_speed(st_r.ctrl[sptx_pkg::C_U2X]),
		.sync_mode(st_r.ctrl[sptx_pkg::C_SYNC]),
		.sync_master(st_r.ctrl[sptx_pkg::C_MSTR]),
		.clk_pol(st_r.ctrl[sptx_pkg::C_POL]),
		.active(st_r.active),
		.xck_in(xck_in),
		.bit_tick(bit_tick),
		.xck_out(xck_out),
		.xck_oe_n(xck_oe_n)
	);

	sptx_shift u_shift (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(load_w),
		.data(st_r.buf_data),
		.nbits(nbits),
		.par_en(st_r.ctrl[sptx_pkg::C_PEN]),
		.par_odd(st_r.ctrl[sptx_pkg::C_PODD]),
		.two_stop(st_r.ctrl[sptx_pkg::C_STOP]),
		.bit_tick(bit_tick),
		.busy(sh_busy),
		.txd(sh_txd),
		.done(sh_done)
	);

	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rresp = st_r.rresp;
	assign s_axi_rdata = st_r.rdata;
	assign txd_out = sh_txd;
	assign txd_oe_n = st_r.oe_n;
	assign irq = st_r.irq;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_pin_owned: assert property (st_r.ctrl[sptx_pkg::C_EN] |-> !txd_oe_n)
		else $error("Enabled transmitter does not own pin"); // [R1]
	a_data_fills: assert property ((st_r.bvalid && !$past(st_r.bvalid)
		&& $past(st_nxt.awaddr == sptx_pkg::ADDR_DATA) && st_r.bresp == sptx_pkg::RESP_OKAY
		&& $past(st_nxt.wstrb[0])) |-> st_r.buf_full || sh_busy)
		else $error("Data write left buffer empty"); // [R12]
	a_ninth_bit: assert property ((st_r.buf_full && !$past(st_r.buf_full))
		|-> st_r.buf_data[8] == $past(st_r.ctrl[sptx_pkg::C_B8]))
		else $error("Ninth bit not taken from control"); // [R7]
	a_move_idle: assert property (load_w |=> sh_busy)
		else $error("Buffer not moved into idle shifter"); // [R4]
	a_empty_irq: assert property ((st_r.ien[0] && !st_r.buf_full) |=> irq)
		else $error("Buffer-empty interrupt dropped"); // [R11]
	a_txc_set: assert property ((sh_done && !st_r.buf_full) |=> st_r.tx_complete)
		else $error("Complete flag missed frame end"); // [R15]
	a_drain_first: assert property ((sh_busy || st_r.buf_full) |=> st_r.active)
		else $error("Transmitter released before draining"); // [R16]
	a_release: assert property ((!st_r.active) |-> txd_oe_n)
		else $error("Pin held while disabled"); // [R16]
	c_txc_event: cover property (sh_done && !st_r.buf_full);
	c_back_to_back: cover property (sh_done && st_r.buf_full);
	c_irq_raised: cover property ($rose(irq));
endmodule
`default_nettype wire

// *** sptx_rx_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Remote receiver: samples the line mid-bit and reports each frame
module sptx_rx_model (
	input wire logic aclk,
	input wire logic line,
	input wire logic [3:0] nbits,
	input wire logic par_en,
	input wire logic two_stop,
	input wire logic [7:0] bit_clks,
	output logic rx_valid,
	output logic [8:0] rx_data,
	output logic rx_par,
	output logic rx_ok
);
	int i;
	initial begin
		rx_valid = 1'b0;
		rx_data = 9'h000;
		rx_par = 1'b0;
		rx_ok = 1'b0;
		forever begin
			@(negedge aclk);
			if (line === 1'b0) begin
				rx_data = 9'h000;
				rx_par = 1'b0;
				repeat (bit_clks / 2) @(negedge aclk);
				rx_ok = (line === 1'b0);
				for (i = 0; i < nbits; i++) begin
					repeat (bit_clks) @(negedge aclk);
					rx_data[i] = line;
				end
				if (par_en) begin
					repeat (bit_clks) @(negedge aclk);
					rx_par = line;
				end
				for (i = 0; i < (two_stop ? 2 : 1); i++) begin
					repeat (bit_clks) @(negedge aclk);
					if (line !== 1'b1) rx_ok = 1'b0;
				end
				rx_valid = 1'b1;
				@(negedge aclk);
				rx_valid = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** sptx_top_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module sptx_top_bench;
	logic aclk = 1'b0;
	logic aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic txd_out, txd_oe_n, xck_in, xck_out, xck_oe_n, irq;
	logic rx_valid, rx_par, rx_ok;
	logic [8:0] rx_data;
	logic [11:0] ctrl_v;
	logic [3:0] m_nb;
	logic [7:0] m_bclk;
	logic [9:0] exp_q[$];
	logic [9:0] exp_f;
	logic [31:0] rnd;
	logic [2:0] csz;
	wire txd_pin;
	int seed, k, num_errors, total_checks;
	// Pin has a pull-up once the transmitter releases it
	assign txd_pin = txd_oe_n ? 1'b1 : txd_out;
	always #50 aclk = ~aclk;
	sptx_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd_out, .txd_oe_n,
		.xck_in, .xck_out, .xck_oe_n, .irq);
	sptx_rx_model i_rx (.aclk, .line(txd_pin), .nbits(m_nb),
		.par_en(ctrl_v[sptx_pkg::C_PEN]), .two_stop(ctrl_v[sptx_pkg::C_STOP]),
		.bit_clks(m_bclk), .rx_valid, .rx_data, .rx_par, .rx_ok);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 200);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 200) num_errors++;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 200);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 200) num_errors++;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		check({30'h0, r}, {30'h0, sptx_pkg::RESP_OKAY});
		check(d, e);
	endtask
	task automatic set_ctrl(input logic [11:0] c);
		logic [1:0] r;
		ctrl_v = c;
		m_nb = (c[11:9] < 3'd4) ? 4'(c[11:9]) + 4'd5 : (c[11:9] == 3'd7 ? 4'd9 : 4'd8);
		m_bclk = c[sptx_pkg::C_U2X] ? 8'd8 : 8'd16;
		axi_wr(sptx_pkg::ADDR_CTRL, {20'h0, c}, r);
	endtask
	task automatic send(input logic [7:0] ch);
		logic [8:0] v;
		logic [31:0] d;
		logic [1:0] r;
		d = 32'h0;
		while (d[sptx_pkg::ST_EMPTY] !== 1'b1) axi_rd(sptx_pkg::ADDR_STAT, d, r);
		v = {ctrl_v[sptx_pkg::C_B8], ch} & ((9'h1 << m_nb) - 9'h1);
		exp_q.push_back({(^v ^ ctrl_v[sptx_pkg::C_PODD]) & ctrl_v[sptx_pkg::C_PEN], v});
		axi_wr(sptx_pkg::ADDR_DATA, {24'h0, ch}, r);
	endtask
	task automatic wait_txc;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		d = 32'h0;
		n = 0;
		while (d[sptx_pkg::ST_TXC] !== 1'b1 && n < 300) begin
			axi_rd(sptx_pkg::ADDR_STAT, d, r);
			n++;
		end
		if (n >= 300) num_errors++;
	endtask
	always @(posedge aclk) begin
		if (rx_valid === 1'b1) begin
			exp_f = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3ff;
			check({21'h0, rx_ok, rx_par, rx_data}, {21'h0, 1'b1, exp_f});
		end
	end
	initial begin
		#5000000;
		num_errors++;
		test_done;
	end
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, xck_in} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		seed = 32'h7944fd6c;
		ctrl_v = sptx_pkg::CTRL_RST;
		m_nb = 4'd8;
		m_bclk = 8'd16;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(sptx_pkg::ADDR_CTRL, 32'h600);
		rd_chk(sptx_pkg::ADDR_IEN, 32'h0);
		rd_chk(sptx_pkg::ADDR_STAT, 32'h1);
		check({31'h0, txd_oe_n}, 32'h1);
		axi_rd(8'h18, rnd, rs);
		check({30'h0, rs}, {30'h0, sptx_pkg::RESP_SLVERR});
		axi_wr(sptx_pkg::ADDR_BAUD, 32'h0, rs);
		$display("test reset_and_map done");
		for (k = 0; k < 12; k++) begin
			rnd = $random(seed);
			csz = 3'(k % 6);
			if (csz == 3'd4) csz = 3'd7;
			set_ctrl({csz, rnd[2:0], 3'b000, rnd[3], rnd[4], 1'b1});
			check({31'h0, txd_oe_n}, 32'h0);
			check({31'h0, txd_out}, 32'h1);
			send(rnd[15:8]);
			send(rnd[23:16]);
			rd_chk(sptx_pkg::ADDR_STAT, 32'h0);
			wait_txc;
			axi_wr(sptx_pkg::ADDR_ICLR, 32'h2, rs);
		end
		$display("test frames done");
		axi_wr(sptx_pkg::ADDR_IEN, 32'h1, rs);
		rd_chk(sptx_pkg::ADDR_STAT, 32'h1);
		check({31'h0, irq}, 32'h1);
		axi_wr(sptx_pkg::ADDR_IEN, 32'h2, rs);
		rd_chk(sptx_pkg::ADDR_IEN, 32'h2);
		check({31'h0, irq}, 32'h0);
		send(8'h5a);
		wait_txc;
		rd_chk(sptx_pkg::ADDR_STAT, 32'h3);
		check({31'h0, irq}, 32'h1);
		axi_wr(sptx_pkg::ADDR_ICLR, 32'h2, rs);
		rd_chk(sptx_pkg::ADDR_STAT, 32'h1);
		check({31'h0, irq}, 32'h0);
		axi_wr(8'h1c, 32'h0, rs);
		check({30'h0, rs}, {30'h0, sptx_pkg::RESP_SLVERR});
		$display("test interrupts done");
		send(8'hc3);
		set_ctrl(ctrl_v & ~12'h001);
		check({31'h0, txd_oe_n}, 32'h0);
		wait_txc;
		check({31'h0, txd_oe_n}, 32'h1);
		$display("test disable done");
		set_ctrl(12'h619);
		repeat (2) @(posedge aclk);
		check({31'h0, xck_oe_n}, 32'h0);
		k = int'(xck_out);
		@(posedge aclk);
		check({31'h0, xck_out}, 32'(k ^ 1));
		$display("test sync_clock done");
		test_done;
	end
endmodule
`default_nettype wire
